// [hw/l1_maint_fsm.sv]
// Purpose: Layer-1 maintenance state machine for a 2048 kbit/s link
// Assumes: 50 MHz clock; events are inputs synchronous to clk
// Notes:   Function
// Function
// - Remote alarm needs frame alignment and an alarm bit of one.
// - AIS is loss of frame plus under three zeros in 512 bits.
// - Loss of signal after more than ten consecutive line zeros.
// - Loss-of-signal detection never stalls frame alignment.
// - Each received E bit of zero reports remote CRC error only.
// - Each local CRC block error in normal or remote failure reports to management only.
// - Send normal, RAI or AIS according to state.
// - Normal frames in local or remote failure: timer, go normal.
// - Signal or frame loss: report; from normal or remote to local.
// - Remote alarm in normal or local failure: report, go remote failure; local adds recovery.
// - AIS: report; from normal or remote go local failure.
// - Internal failure: non-operational, report, enter internal state.
// - Internal failure clears: report recovery, go remote failure.
// - Timer expiry: operational in normal, non-operational in local or remote failure.
// - Starting the timer clears any timer already running.
// - Timer presets 100 ms to 25 s, per event.
// - Timer within 50 ms up to 1 s, 10 % beyond.
// - Access side uses longer deactivate, shorter activate settings.
// - Events reported to management immediately.
// - Each operational change signalled activate or deactivate.
// - Suspend request withholds error reports, machine keeps running.
// - Resume request resends last error report, forwards later ones.
// - CRC active in normal and remote failure; errors send E zero.
`timescale 1ns/1ns
module l1_maint_fsm
   import l1_maint_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES,
   // Settings in 100 ms steps, per triggering event
   parameter logic [7:0]  T_NORMAL = 8'h05,
   parameter logic [7:0]  T_LOSS   = 8'h0a,
   parameter logic [7:0]  T_RAI    = 8'h0a,
   parameter logic [7:0]  T_AIS    = 8'h0a
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Received line
   input  wire logic       bit_en,
   input  wire logic       line_zero,
   input  wire logic       bin_bit,
   input  wire logic       frame_aligned,
   input  wire logic       loss_of_frame,
   input  wire logic       a_bit_en,
   input  wire logic       a_bit,
   input  wire logic       e_bit_en,
   input  wire logic       e_bit,
   input  wire logic       crc_blk_en,
   input  wire logic       crc_blk_err,
   // Local conditions
   input  wire logic       internal_fail,
   // Management requests
   input  wire logic       suspend_error_reports,
   input  wire logic       resume_error_reports,
   // Transmit control
   output tx_sig_t         tx_signal,
   output logic            tx_e_zero,
   // Management indications
   output logic            link_operational_ind,
   output logic            link_nonoperational_ind,
   output logic            err_ind_signal_frame_loss,
   output logic            err_ind_remote_alarm,
   output logic            err_ind_alarm_signal,
   output logic            err_ind_internal_fail,
   output logic            err_ind_local_crc,
   output logic            err_ind_remote_crc,
   output logic            err_ind_recovery,
   output l1_state_t       state
);
   localparam int unsigned TW = $clog2(TICK_LEN);

   // ==========================================================
   // Line condition detection
   logic los, rai, ais;

   l1_signal_detect u_det (
      .clk           (clk),
      .srst          (srst),
      .bit_en        (bit_en),
      .line_zero     (line_zero),
      .bin_bit       (bin_bit),
      .frame_aligned (frame_aligned),
      .loss_of_frame (loss_of_frame),
      .a_bit_en      (a_bit_en),
      .a_bit         (a_bit),
      .los           (los),
      .rai           (rai),
      .ais           (ais)
   );

   // ==========================================================
   // State
   typedef struct packed {
      l1_state_t   st;
      logic        loss_l;
      logic        rai_l;
      logic        ais_l;
      logic        intf_l;
      logic        nf_l;
      logic [TW-1:0] pre;
      logic [7:0]  tmr;
      logic        run;
      logic        mute;
      rep_t        last;
      logic        last_r;
      rep_t        rep;
      logic        rep_r;
      rep_t        pend;
      logic        ai;
      logic        di;
      logic        ez;
      tx_sig_t     tx;
   } fsm_t;

   fsm_t q, d;

   logic normal_frames;
   assign normal_frames = frame_aligned && !rai && !ais && !los;

   function automatic logic [7:0] clamp_set(input logic [7:0] v);
      if (v < TSET_MIN)
         return TSET_MIN;
      else if (v > TSET_MAX)
         return TSET_MAX;
      return v;
   endfunction : clamp_set

   // ==========================================================
   // Next state
   always_comb begin
      logic       loss_ev, rai_ev, ais_ev, int_ev, clr_ev, nf_ev, tick, start;
      logic [7:0] tset;
      rep_t       r;
      logic       rr;
      loss_ev = (los || loss_of_frame) && !q.loss_l;
      rai_ev  = rai && !q.rai_l;
      ais_ev  = ais && !q.ais_l;
      int_ev  = internal_fail && !q.intf_l;
      clr_ev  = !internal_fail && q.intf_l;
      nf_ev   = normal_frames && !q.nf_l;
      start   = 1'b0;
      tset    = T_NORMAL;
      r       = rep_none;
      rr      = 1'b0;
      d       = q;
      d.loss_l = los || loss_of_frame;
      d.rai_l  = rai;
      d.ais_l  = ais;
      d.intf_l = internal_fail;
      d.nf_l   = normal_frames;
      d.ai     = 1'b0;
      d.di     = 1'b0;
      d.rep    = rep_none;
      d.rep_r  = 1'b0;
      d.pend   = rep_none;
      tick     = (q.pre == TW'(TICK_LEN - 1));
      d.pre    = tick ? '0 : q.pre + TW'(1);

      // Timer expiry, one per run
      if (q.run && tick) begin
         if (q.tmr == 8'h01) begin
            d.run = 1'b0;
            unique case (q.st)
               state_normal:  d.ai = 1'b1;
               state_local_failure,
               state_remote_failure: d.di = 1'b1;
               state_internal_failure: ;
            endcase
         end else begin
            d.tmr = q.tmr - 8'h01;
         end
      end

      if (int_ev && q.st != state_internal_failure) begin
         d.di = 1'b1;
         r    = rep_intf;
         d.st = state_internal_failure;
         d.run = 1'b0;
      end else if (clr_ev) begin
         if (q.st == state_internal_failure) begin
            r    = rep_intf;
            rr   = 1'b1;
            d.st = state_remote_failure;
         end
      end else if (loss_ev) begin
         r = rep_loss;
         if (q.st == state_normal) begin
            start = 1'b1;
            tset  = T_LOSS;
            d.st  = state_local_failure;
         end else if (q.st == state_remote_failure) begin
            d.rep   = rep_rai;
            d.rep_r = 1'b1;
            d.st    = state_local_failure;
         end
      end else if (ais_ev) begin
         r = rep_ais;
         if (q.st == state_normal) begin
            start = 1'b1;
            tset  = T_AIS;
            d.st  = state_local_failure;
         end else if (q.st == state_remote_failure) begin
            d.rep   = rep_rai;
            d.rep_r = 1'b1;
            d.st    = state_local_failure;
         end
      end else if (rai_ev) begin
         if (q.st == state_normal) begin
            r     = rep_rai;
            start = 1'b1;
            tset  = T_RAI;
            d.st  = state_remote_failure;
         end else if (q.st == state_local_failure) begin
            r       = rep_rai;
            d.rep   = rep_loss;
            d.rep_r = 1'b1;
            d.st    = state_remote_failure;
         end
      end else if (nf_ev) begin
         if (q.st == state_local_failure ||
             q.st == state_remote_failure) begin
            start = 1'b1;
            tset  = T_NORMAL;
            d.st  = state_normal;
         end
      end

      // New run replaces any running one
      if (start) begin
         d.run = 1'b1;
         d.tmr = clamp_set(tset);
         d.pre = '0;
      end

      // CRC reports never move the machine
      d.ez = crc_blk_en && crc_blk_err &&
             (q.st == state_normal || q.st == state_remote_failure);
      if (d.ez && r == rep_none)
         r = rep_lcrc;
      if (e_bit_en && !e_bit && r == rep_none)
         r = rep_rcrc;

      // Recovery report of a pair goes out now; the event's own report a cycle later
      if (d.rep == rep_none)
         d.rep = q.pend;
      if (r != rep_none) begin
         d.last   = r;
         d.last_r = rr;
         if (d.rep == rep_none) begin
            d.rep   = r;
            d.rep_r = rr;
         end else
            d.pend = r;
      end
      if (resume_error_reports) begin
         d.mute = 1'b0;
         if (r == rep_none && q.last != rep_none) begin
            d.rep   = q.last;
            d.rep_r = q.last_r;
         end
      end else if (suspend_error_reports) begin
         d.mute = 1'b1;
      end
      if (d.mute) begin
         d.rep   = rep_none;
         d.rep_r = 1'b0;
      end

      unique case (d.st)
         state_normal, state_remote_failure: d.tx = tx_normal;
         state_local_failure:                d.tx = tx_rai;
         state_internal_failure:             d.tx = tx_ais;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q    <= '0;
         q.st <= state_local_failure;
         q.tx <= tx_rai;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign state                     = q.st;
   assign tx_signal                 = q.tx;
   assign tx_e_zero                 = q.ez;
   assign link_operational_ind      = q.ai;
   assign link_nonoperational_ind   = q.di;
   assign err_ind_signal_frame_loss = (q.rep == rep_loss);
   assign err_ind_remote_alarm      = (q.rep == rep_rai);
   assign err_ind_alarm_signal      = (q.rep == rep_ais);
   assign err_ind_internal_fail     = (q.rep == rep_intf);
   assign err_ind_local_crc         = (q.rep == rep_lcrc);
   assign err_ind_remote_crc        = (q.rep == rep_rcrc);
   assign err_ind_recovery          = q.rep_r;

   // ==========================================================
   // Checks
   sequence s_int_rise;
      !$past(internal_fail) && internal_fail &&
      state != state_internal_failure;
   endsequence

   a_int_enter: assert property (@(posedge clk) disable iff (srst)
      s_int_rise |=> state == state_internal_failure &&
                     link_nonoperational_ind)
      else $error("internal failure not entered");
   a_tx_state: assert property (@(posedge clk) disable iff (srst)
      (state == state_local_failure) == (tx_signal == tx_rai))
      else $error("transmit signal does not match state");
   a_int_clear: assert property (@(posedge clk) disable iff (srst)
      state == state_internal_failure && $past(internal_fail) &&
      !internal_fail |=> state == state_remote_failure)
      else $error("internal failure clear not handled");
   a_mute_quiet: assert property (@(posedge clk) disable iff (srst)
      q.mute && !resume_error_reports |=> !err_ind_local_crc &&
      !err_ind_remote_crc && !err_ind_signal_frame_loss)
      else $error("report while suspended");
   a_crc_nomove: assert property (@(posedge clk) disable iff (srst)
      err_ind_local_crc |-> $stable(state))
      else $error("CRC report moved state");
   a_ai_normal: assert property (@(posedge clk) disable iff (srst)
      link_operational_ind |-> $past(state) == state_normal)
      else $error("activate outside normal state");
   a_timer_rng: assert property (@(posedge clk) disable iff (srst)
      q.run |-> q.tmr >= TSET_MIN && q.tmr <= TSET_MAX)
      else $error("timer outside preset range");
   a_ez_state: assert property (@(posedge clk) disable iff (srst)
      tx_e_zero |-> $past(state) inside {state_normal,
                                          state_remote_failure})
      else $error("E bit zero sent outside CRC states");
endmodule : l1_maint_fsm

// [hw/l1_maint_pkg.sv]
// Purpose: Constants and types for the layer-1 maintenance block
// Assumes: 50 MHz system clock
// Notes:   Timer settings are in 100 ms units
package l1_maint_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned TICK_MS       = 100;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W        = $clog2(TICK_CYCLES);
   // Settings 1..250 steps of 100 ms
   localparam int unsigned TSET_W        = 8;
   localparam logic [7:0]  TSET_MIN      = 8'h01;
   localparam logic [7:0]  TSET_MAX      = 8'hfa;
   localparam int unsigned LOS_ZEROS     = 10;
   localparam int unsigned AIS_WINDOW    = 512;
   localparam int unsigned AIS_MAX_ZEROS = 3;

   // Gray codes along normal path
   typedef enum logic [1:0] {
      state_local_failure    = 2'h0,
      state_normal           = 2'h1,
      state_remote_failure   = 2'h3,
      state_internal_failure = 2'h2
   } l1_state_t;

   // Line signal to transmit
   typedef enum logic [1:0] {
      tx_normal = 2'h0,
      tx_rai    = 2'h1,
      tx_ais    = 2'h2
   } tx_sig_t;

   // Error report codes, index of last report
   typedef enum logic [2:0] {
      rep_none    = 3'h0,
      rep_loss    = 3'h1,
      rep_rai     = 3'h2,
      rep_ais     = 3'h3,
      rep_intf    = 3'h4,
      rep_lcrc    = 3'h5,
      rep_rcrc    = 3'h6
   } rep_t;
endpackage : l1_maint_pkg

// [hw/l1_signal_detect.sv]
// Purpose: Line event detection: loss of signal, remote alarm, AIS
// Assumes: One received bit per bit_en pulse, synchronous inputs
// Notes:   Runs beside the frame aligner and never gates it
`timescale 1ns/1ns
module l1_signal_detect
   import l1_maint_pkg::*;
#(
   parameter int unsigned WIN  = AIS_WINDOW,
   parameter int unsigned LOSZ = LOS_ZEROS
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Received stream
   input  wire logic bit_en,
   input  wire logic line_zero,
   input  wire logic bin_bit,
   input  wire logic frame_aligned,
   input  wire logic loss_of_frame,
   input  wire logic a_bit_en,
   input  wire logic a_bit,
   // Detected conditions
   output logic      los,
   output logic      rai,
   output logic      ais
);
   localparam int unsigned WW = $clog2(WIN + 1);

   typedef struct packed {
      logic [4:0]    zrun;
      logic [WW-1:0] wcnt;
      logic [1:0]    zcnt;
      logic          los;
      logic          rai;
      logic          ais;
   } det_t;

   det_t q, d;

   always_comb begin
      d = q;
      if (bit_en) begin
         // Zero run in line code; a mark ends it
         if (!line_zero) begin
            d.zrun = 5'h00;
            d.los  = 1'b0;
         end else if (q.zrun > 5'(LOSZ)) begin
            d.los = 1'b1;
         end else begin
            d.zrun = q.zrun + 5'h01;
            d.los  = (q.zrun == 5'(LOSZ));
         end
         // Count zeros over a fixed bit window
         if (q.wcnt == WW'(WIN - 1)) begin
            d.wcnt = '0;
            d.zcnt = 2'h0;
            d.ais  = loss_of_frame &&
                     (32'(q.zcnt) + 32'(!bin_bit) < AIS_MAX_ZEROS);
         end else begin
            d.wcnt = q.wcnt + WW'(1);
            if (!bin_bit && q.zcnt != 2'h3)
               d.zcnt = q.zcnt + 2'h1;
         end
      end
      if (!loss_of_frame)
         d.ais = 1'b0;
      // Alarm bit judged only while aligned
      if (!frame_aligned)
         d.rai = 1'b0;
      else if (a_bit_en)
         d.rai = a_bit;
   end

   always_ff @(posedge clk) begin
      if (srst)
         q <= '0;
      else
         q <= d;
   end

   assign los = q.los;
   assign rai = q.rai;
   assign ais = q.ais;

   a_rai_aligned: assert property (@(posedge clk) disable iff (srst)
      rai |-> $past(frame_aligned))
      else $error("remote alarm set while not aligned");
   a_ais_lof: assert property (@(posedge clk) disable iff (srst)
      $rose(ais) |-> $past(loss_of_frame))
      else $error("AIS raised without loss of frame");
endmodule : l1_signal_detect

// [sim/line_far_end.sv]
// Purpose: Far-end line terminal feeding the received side of the block
// Assumes: One received bit every second clock; aligner status set by mode
// Notes:   Qualified data toggles between strobes so nothing stale looks valid
`timescale 1ns/1ns
module line_far_end (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Bench control
   input  wire logic [2:0] mode,
   input  wire logic       inj_crc,
   input  wire logic       inj_e,
   // Received line towards the block
   output logic            bit_en,
   output logic            line_zero,
   output logic            bin_bit,
   output logic            frame_aligned,
   output logic            loss_of_frame,
   output logic            a_bit_en,
   output logic            a_bit,
   output logic            e_bit_en,
   output logic            e_bit,
   output logic            crc_blk_en,
   output logic            crc_blk_err
);
   logic [5:0] ph_q;
   logic [3:0] zc_q;
   logic       crc_q;
   logic       e_q;

   initial {bit_en, line_zero, bin_bit, frame_aligned, loss_of_frame} = '0;
   initial {a_bit_en, a_bit, e_bit_en, e_bit, crc_blk_en, crc_blk_err} = '0;

   // ==========================================================
   // Line generator: 0 down, 1 normal, 2 silent, 3 AIS, 4 RAI,
   // 5 runs of ten zeros
   always @(posedge clk) begin
      bit_en      <= 1'b0;
      a_bit_en    <= 1'b0;
      e_bit_en    <= 1'b0;
      crc_blk_en  <= 1'b0;
      line_zero   <= ~line_zero;
      bin_bit     <= ~bin_bit;
      a_bit       <= ~a_bit;
      e_bit       <= ~e_bit;
      crc_blk_err <= ~crc_blk_err;
      crc_q       <= crc_q | inj_crc;
      e_q         <= e_q | inj_e;
      if (srst) begin
         ph_q          <= 6'h00;
         zc_q          <= 4'h0;
         crc_q         <= 1'b0;
         e_q           <= 1'b0;
         frame_aligned <= 1'b0;
         loss_of_frame <= 1'b0;
      end else if (!bit_en) begin
         bit_en        <= 1'b1;
         ph_q          <= ph_q + 6'h01;
         zc_q          <= (zc_q == 4'ha) ? 4'h0 : zc_q + 4'h1;
         frame_aligned <= (mode != 3'h0) && (mode != 3'h3);
         loss_of_frame <= (mode == 3'h3);
         bin_bit       <= (mode == 3'h3) | ph_q[1];
         case (mode)
            3'h2: line_zero <= 1'b1;
            3'h3: line_zero <= 1'b0;
            3'h5: line_zero <= (zc_q != 4'ha);
            default: line_zero <= ph_q[0];
         endcase
         a_bit_en <= (ph_q[2:0] == 3'h0);
         a_bit    <= (mode == 3'h4) || (mode == 3'h3);
         if (ph_q[2:0] == 3'h2) begin
            crc_blk_en  <= 1'b1;
            crc_blk_err <= crc_q;
            crc_q       <= inj_crc;
         end
         if (ph_q[2:0] == 3'h5) begin
            e_bit_en <= 1'b1;
            e_bit    <= ~e_q;
            e_q      <= inj_e;
         end
      end
   end
endmodule : line_far_end

// [sim/testbench.sv]
// Purpose: Self-checking bench for the layer-1 maintenance machine
// Assumes: Prescaler cut to TL cycles per 100 ms tick
// Notes:   Indication pulses are counted per output, except err_ind_recovery
`timescale 1ns/1ns
module testbench;
   import l1_maint_pkg::*;

   localparam int unsigned TL      = 10;
   localparam int          NRM_CYC = 5 * TL;
   localparam int          LOS_CYC = 10 * TL;
   localparam int          LIMIT   = 6000;

   logic       clk;
   logic       srst;
   logic       internal_fail;
   logic       suspend_error_reports;
   logic       resume_error_reports;
   logic [2:0] mode;
   logic       inj_crc;
   logic       inj_e;
   logic       bit_en, line_zero, bin_bit, frame_aligned, loss_of_frame;
   logic       a_bit_en, a_bit, e_bit_en, e_bit, crc_blk_en, crc_blk_err;
   tx_sig_t    tx_signal;
   l1_state_t  state;
   logic       tx_e_zero, link_operational_ind, link_nonoperational_ind;
   logic       err_ind_signal_frame_loss, err_ind_remote_alarm;
   logic       err_ind_alarm_signal, err_ind_internal_fail;
   logic       err_ind_local_crc, err_ind_remote_crc, err_ind_recovery;
   logic [8:0] ind;
   int         cnt [9];
   int         base [9];
   int         num_errors = 0;
   int         checked = 0;
   int         cycles = 0;

   assign ind = {tx_e_zero, err_ind_remote_crc, err_ind_local_crc,
                 err_ind_internal_fail, err_ind_alarm_signal,
                 err_ind_remote_alarm, err_ind_signal_frame_loss,
                 link_nonoperational_ind, link_operational_ind};

   l1_maint_fsm #(.TICK_LEN(TL)) l1_maint_fsm_inst (
      .clk, .srst, .bit_en, .line_zero, .bin_bit, .frame_aligned,
      .loss_of_frame, .a_bit_en, .a_bit, .e_bit_en, .e_bit, .crc_blk_en,
      .crc_blk_err, .internal_fail, .suspend_error_reports,
      .resume_error_reports, .tx_signal, .tx_e_zero, .link_operational_ind,
      .link_nonoperational_ind, .err_ind_signal_frame_loss,
      .err_ind_remote_alarm, .err_ind_alarm_signal, .err_ind_internal_fail,
      .err_ind_local_crc, .err_ind_remote_crc, .err_ind_recovery, .state
   );

   line_far_end line_far_end_inst (
      .clk, .srst, .mode, .inj_crc, .inj_e, .bit_en, .line_zero, .bin_bit,
      .frame_aligned, .loss_of_frame, .a_bit_en, .a_bit, .e_bit_en, .e_bit,
      .crc_blk_en, .crc_blk_err
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      for (int i = 0; i < 9; i++) begin
         if (ind[i] === 1'b1) cnt[i]++;
      end
      if (cycles == LIMIT) begin
         num_errors++;
         complete_run();
      end
   end

   // ==========================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [15:0] dlt(input int i);
      return 16'(cnt[i] - base[i]);
   endfunction : dlt

   task automatic snap();
      foreach (base[i]) base[i] = cnt[i];
   endtask : snap

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic set_mode(input logic [2:0] m);
      @(posedge clk);
      mode <= m;
   endtask : set_mode

   task automatic req(input logic s, input logic r, input logic c);
      @(posedge clk);
      suspend_error_reports <= s;
      resume_error_reports  <= r;
      inj_crc               <= c;
      @(posedge clk);
      suspend_error_reports <= 1'b0;
      resume_error_reports  <= 1'b0;
      inj_crc               <= 1'b0;
   endtask : req

   task automatic wait_ind(input int i, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ind[i] !== 1'b1 && n < lim);
      chk(16'(ind[i]), 16'h1);
   endtask : wait_ind

   task automatic complete_run();
      if (num_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // ==========================================================
   // Scenarios
   task automatic t_normal();
      int n;
      snap();
      set_mode(3'h5);
      wait_ind(0, NRM_CYC + 30, n);
      chk(16'(n >= NRM_CYC && n <= NRM_CYC + 8), 16'h1);
      chk(16'(state), 16'(state_normal));
      chk(16'(tx_signal), 16'(tx_normal));
      chk(dlt(1), 16'h0);
      cyc(40);
      chk(dlt(2), 16'h0);
   endtask : t_normal

   task automatic t_crc();
      snap();
      @(posedge clk);
      inj_e <= 1'b1;
      @(posedge clk);
      inj_e <= 1'b0;
      req(1'b0, 1'b0, 1'b1);
      cyc(40);
      chk(dlt(6), 16'h1);
      chk(dlt(8), 16'h1);
      chk(dlt(7), 16'h1);
      chk(16'(state), 16'(state_normal));
   endtask : t_crc

   task automatic t_mute();
      snap();
      req(1'b1, 1'b0, 1'b0);
      req(1'b0, 1'b0, 1'b1);
      cyc(40);
      chk(dlt(6), 16'h0);
      chk(dlt(8), 16'h1);
      req(1'b0, 1'b1, 1'b0);
      cyc(5);
      chk(dlt(6), 16'h1);
      req(1'b0, 1'b0, 1'b1);
      cyc(40);
      chk(dlt(6), 16'h2);
   endtask : t_mute

   task automatic t_los();
      int n;
      set_mode(3'h2);
      wait_ind(2, 60, n);
      chk(16'(state), 16'(state_local_failure));
      chk(16'(tx_signal), 16'(tx_rai));
      wait_ind(1, LOS_CYC + 20, n);
      chk(16'(n >= LOS_CYC - 3 && n <= LOS_CYC + 3), 16'h1);
   endtask : t_los

   task automatic t_restart();
      int n;
      set_mode(3'h1);
      cyc(12);
      chk(16'(state), 16'(state_normal));
      set_mode(3'h4);
      wait_ind(3, 40, n);
      chk(16'(state), 16'(state_remote_failure));
      chk(16'(tx_signal), 16'(tx_normal));
      snap();
      cyc(70);
      chk(dlt(0), 16'h0);
      wait_ind(1, 60, n);
   endtask : t_restart

   task automatic t_ais();
      int n;
      snap();
      set_mode(3'h3);
      wait_ind(3, 20, n);
      chk(16'(err_ind_recovery), 16'h1);
      chk(16'(state), 16'(state_local_failure));
      wait_ind(4, 2200, n);
      chk(16'(state), 16'(state_local_failure));
      chk(dlt(3), 16'h1);
      chk(dlt(2), 16'h1);
   endtask : t_ais

   task automatic t_intf();
      int n;
      @(posedge clk);
      internal_fail <= 1'b1;
      wait_ind(5, 10, n);
      chk(16'(n <= 2), 16'h1);
      chk(16'(link_nonoperational_ind), 16'h1);
      chk(16'(err_ind_recovery), 16'h0);
      chk(16'(state), 16'(state_internal_failure));
      chk(16'(tx_signal), 16'(tx_ais));
      set_mode(3'h1);
      cyc(40);
      chk(16'(state), 16'(state_internal_failure));
      @(posedge clk);
      internal_fail <= 1'b0;
      wait_ind(5, 10, n);
      chk(16'(err_ind_recovery), 16'h1);
      chk(16'(state), 16'(state_remote_failure));
   endtask : t_intf

   // ==========================================================
   // Main sequence
   initial begin
      srst                  = 1'b1;
      internal_fail         = 1'b0;
      suspend_error_reports = 1'b0;
      resume_error_reports  = 1'b0;
      mode                  = 3'h0;
      inj_crc               = 1'b0;
      inj_e                 = 1'b0;
      cyc(9);
      chk(16'(state), 16'(state_local_failure));
      chk(16'(tx_signal), 16'(tx_rai));
      @(posedge clk);
      srst <= 1'b0;
      t_normal();
      t_crc();
      t_mute();
      t_los();
      t_restart();
      t_ais();
      t_intf();
      complete_run();
   end
endmodule : testbench
